// file: verilog/tci_params.svh
`ifndef TCI_PARAMS_SVH
`define TCI_PARAMS_SVH
// APB register byte offsets
`define TCI_OFF_CTRL    12'h000
`define TCI_OFF_FUNC    12'h004
`define TCI_OFF_STATUS  12'h008
`define TCI_OFF_EVENT   12'h00C
`define TCI_OFF_RDATA   12'h010
`define TCI_OFF_WDATA   12'h014
// Control register fields
`define TCI_CTRL_CONNECT   0
`define TCI_CTRL_HSEL_LSB  1
`define TCI_CTRL_HSEL_MSB  3
// Function register fields
`define TCI_FN_IRQ_SEL     0
`define TCI_FN_EN_READY    1
`define TCI_FN_EN_EOP      2
`define TCI_FN_EN_ABN      3
`define TCI_FN_REW_UNLOAD  4
`define TCI_FN_READ        5
`define TCI_FN_WRITE       6
`define TCI_FN_CLR_UNLOAD  7
// Reset values
`define TCI_CTRL_RST       4'h0
`define TCI_COND_RST       3'h0
// Timing: clock rate and delays
`define TCI_CLK_MHZ        100
`define TCI_ABN_DLY_US     5
`define TCI_ABN_DLY_CYC    (`TCI_ABN_DLY_US * `TCI_CLK_MHZ)
`define TCI_FRAME_NS       20000
`define TCI_FRAME_CYC      ((`TCI_FRAME_NS + 9) / 10)
`define TCI_LOST_FRAMES    2
`define TCI_LOST_CYC       (`TCI_LOST_FRAMES * `TCI_FRAME_CYC)
`endif

// file: verilog/tci_pkg.sv
package tci_pkg;
	// Handler status as seen on the cable
	typedef struct packed {
		logic ready;
		logic busy;
		logic write_en;
		logic file_mark;
		logic load_point;
		logic end_of_tape;
		logic dens_556;
		logic dens_800;
		logic end_of_record;
	} tci_hdl_t;

	// Controller internal state feeding status
	typedef struct packed {
		logic write_ctl;
		logic read_ctl;
		logic write_motion;
		logic vpar_err;
		logic lpar_err;
		logic search;
	} tci_ctl_t;

	// Abnormal interrupt delay states
	typedef enum logic [1:0] {
		TCI_DLY_IDLE = 2'b00,
		TCI_DLY_RUN  = 2'b01,
		TCI_DLY_FIRE = 2'b10
	} tci_dly_t;
endpackage

// file: verilog/tci_sync.sv
module tci_sync (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_ce,
	// Async level in, synced level out
	input  wire logic i_d,
	output logic      o_q
);
	logic meta_ff;
	logic sync_ff;

	// Two flops; first stage read only by second
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else if (i_ce) begin
			meta_ff <= i_d;
			sync_ff <= meta_ff;
		end
	end

	assign o_q = sync_ff;
endmodule

// file: verilog/tci_timer.sv
module tci_timer #(
	parameter int W = 10
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_ce,
	// Control
	input  wire logic         i_clr,
	input  wire logic         i_run,
	input  wire logic [W-1:0] i_limit,
	// Reached limit, level while held
	output logic              o_done
);
	logic [W-1:0] cnt_ff;

	// Counts while run, restarts on clear or idle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_ff <= '0;
		end else if (i_ce) begin
			if (i_clr || !i_run) begin
				cnt_ff <= '0;
			end else if (cnt_ff != i_limit) begin
				cnt_ff <= cnt_ff + W'(1);
			end
		end
	end

	assign o_done = i_run && (cnt_ff == i_limit);
endmodule

// file: verilog/tci_top.sv
// Notes on behaviour
// - Rewind-unload handler is unusable until reload
// - Three interrupt-condition flags set by functions
// - Ready and not busy raises interrupt
// - Interrupt flag drives line and lamp
// - Interrupt holds until new select or conditions cleared
// - End of record with idle-seen raises interrupt
// - Channel busy falling sets idle-seen flag
// - Abnormal conditions at end of record interrupt
// - Abnormal interrupt blocks new tape motion
// - Improper ready drop raises abnormal interrupt
// - Eleven status lines readable any time
// - Status lines enabled only while connected
// - Bit 0 ready, bit 1 ready and active
// - Bits 2-5 write enable, mark, load, end
// - Bits 6-7 encode density
// - Bits 8-10 lost, end op, parity
// - Write data gap of two frames loses
// - Lost data sets bit, interrupt, blocks writes
// - Lost data cleared by function, connect, clear
// - Read word held until host drops data
// - Unaccepted word at next frame loses data
// - Read lost interrupt 5 us after record end
// - Read lost sets record disconnect, blocks reads
//
// Local design decisions: the APB slave port and the address map.
module tci_top (
	// Clock, reset, enable
	input  wire logic                 I_REF_CLK,
	input  wire logic                 I_RST,
	input  wire logic                 I_CE,
	// APB slave
	input  wire logic                 I_PSEL,
	input  wire logic                 I_PENABLE,
	input  wire logic                 I_PWRITE,
	input  wire logic [11:0]          I_PADDR,
	input  wire logic [31:0]          I_PWDATA,
	output logic      [31:0]          O_PRDATA,
	output logic                      O_PREADY,
	output logic                      O_PSLVERR,
	// Data channel pins
	input  wire logic                 I_CHAN_BUSY,
	input  wire logic                 I_CHAN_DATA,
	input  wire logic                 I_CHAN_INT,
	output logic                      O_INTERRUPT,
	output logic                      O_INT_LAMP,
	output logic                      O_EOR_TO_CHAN,
	output logic      [10:0]          O_STATUS,
	// Tape handler pins
	input  wire tci_pkg::tci_hdl_t    I_HDL,
	input  wire logic                 I_READ_SPROCKET,
	input  wire logic                 I_CHECK_CHAR,
	output logic                      O_REWIND_UNLOAD,
	output logic                      O_READ_START,
	output logic                      O_WRITE_SELECT,
	// Internal controller state
	input  wire tci_pkg::tci_ctl_t    I_CTL
);
`include "tci_params.svh"

	logic [3:0]  ctrl_ff;
	logic        int_ff, en_ready_ff, en_eop_ff, en_abn_ff;
	logic        idle_seen_ff, lost_ff, abn_hit_ff, eor_disc_ff;
	logic        rew_unl_ff, read_ff, write_ff, ready_d_ff;
	logic [7:0]  unload_ff;
	logic [31:0] rdata_ff, wdata_ff, hold_ff;
	logic        hold_full_ff, busy_d_ff, eor_d_ff, spr_d_ff;
	tci_pkg::tci_dly_t dly_ff;
	tci_pkg::tci_hdl_t hdl_s;
	logic        chan_busy_s, chan_data_s, chan_int_s, spr_s, chk_s;
	logic        wr_acc, rd_acc, fn_wr, ctrl_wr, connect_new;
	logic        eor_rise, spr_rise, busy_fall, abn_cond, motion_ok;
	logic        lost_wr, lost_rd, dly_done, unusable;
	logic [31:0] fn;
	logic [2:0]  hsel;
	logic [10:0] status_raw;

	// Synchronise every pin input
	genvar g;
	for (g = 0; g < 9; g++) begin : g_hdl
		tci_sync u_s (.i_clk(I_REF_CLK), .i_rst(I_RST), .i_ce(I_CE),
			.i_d(I_HDL[g]), .o_q(hdl_s[g]));
	end
	tci_sync u_cb (.i_clk(I_REF_CLK), .i_rst(I_RST), .i_ce(I_CE),
		.i_d(I_CHAN_BUSY), .o_q(chan_busy_s));
	tci_sync u_cd (.i_clk(I_REF_CLK), .i_rst(I_RST), .i_ce(I_CE),
		.i_d(I_CHAN_DATA), .o_q(chan_data_s));
	tci_sync u_ci (.i_clk(I_REF_CLK), .i_rst(I_RST), .i_ce(I_CE),
		.i_d(I_CHAN_INT), .o_q(chan_int_s));
	tci_sync u_sp (.i_clk(I_REF_CLK), .i_rst(I_RST), .i_ce(I_CE),
		.i_d(I_READ_SPROCKET), .o_q(spr_s));
	tci_sync u_ck (.i_clk(I_REF_CLK), .i_rst(I_RST), .i_ce(I_CE),
		.i_d(I_CHECK_CHAR), .o_q(chk_s));

	// APB decode; zero-wait slave
	assign wr_acc      = I_PSEL && I_PENABLE && I_PWRITE;
	assign rd_acc      = I_PSEL && I_PENABLE && !I_PWRITE;
	assign fn_wr       = wr_acc && (I_PADDR == `TCI_OFF_FUNC);
	assign ctrl_wr     = wr_acc && (I_PADDR == `TCI_OFF_CTRL);
	assign fn          = I_PWDATA;
	assign connect_new = ctrl_wr && I_PWDATA[`TCI_CTRL_CONNECT] && !ctrl_ff[0];
	assign hsel        = ctrl_ff[`TCI_CTRL_HSEL_MSB:`TCI_CTRL_HSEL_LSB];
	assign O_PREADY    = 1'b1;
	assign O_PSLVERR   = I_PSEL && I_PENABLE && !(I_PADDR == `TCI_OFF_CTRL
		|| I_PADDR == `TCI_OFF_FUNC || I_PADDR == `TCI_OFF_STATUS
		|| I_PADDR == `TCI_OFF_EVENT || I_PADDR == `TCI_OFF_RDATA
		|| I_PADDR == `TCI_OFF_WDATA);

	// Edge detection on synced levels
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			busy_d_ff  <= 1'b0;
			eor_d_ff   <= 1'b0;
			spr_d_ff   <= 1'b0;
			ready_d_ff <= 1'b0;
		end else if (I_CE) begin
			busy_d_ff  <= chan_busy_s;
			eor_d_ff   <= hdl_s.end_of_record;
			spr_d_ff   <= spr_s;
			ready_d_ff <= hdl_s.ready;
		end
	end
	assign busy_fall = busy_d_ff && !chan_busy_s;
	assign eor_rise  = hdl_s.end_of_record && !eor_d_ff;
	assign spr_rise  = spr_s && !spr_d_ff;

	// Connect and handler select
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			ctrl_ff <= `TCI_CTRL_RST;
		end else if (I_CE && ctrl_wr) begin
			ctrl_ff <= I_PWDATA[3:0];
		end
	end

	// Interrupt-condition flags, master clear zeroes them
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			{en_abn_ff, en_eop_ff, en_ready_ff} <= `TCI_COND_RST;
		end else if (I_CE && fn_wr && fn[`TCI_FN_IRQ_SEL]) begin
			en_ready_ff <= fn[`TCI_FN_EN_READY];
			en_eop_ff   <= fn[`TCI_FN_EN_EOP];
			en_abn_ff   <= fn[`TCI_FN_EN_ABN];
		end
	end

	// Idle-seen flag; a set wins over function clear
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			idle_seen_ff <= 1'b0;
		end else if (I_CE) begin
			if (busy_fall) begin
				idle_seen_ff <= 1'b1;
			end else if (fn_wr) begin
				idle_seen_ff <= 1'b0;
			end
		end
	end

	// Abnormal conditions sampled at end of record
	assign abn_cond = lost_ff || I_CTL.lpar_err || I_CTL.vpar_err
		|| hdl_s.load_point || (I_CTL.search && hdl_s.file_mark)
		|| hdl_s.end_of_tape;

	// Delay 5 us after record end when read data lost
	tci_timer #(.W(10)) u_dly (
		.i_clk   (I_REF_CLK),
		.i_rst   (I_RST),
		.i_ce    (I_CE),
		.i_clr   (fn_wr),
		.i_run   (dly_ff == tci_pkg::TCI_DLY_RUN),
		.i_limit (10'(`TCI_ABN_DLY_CYC - 1)),
		.o_done  (dly_done)
	);
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			dly_ff <= tci_pkg::TCI_DLY_IDLE;
		end else if (I_CE) begin
			case (dly_ff)
				tci_pkg::TCI_DLY_IDLE: begin
					if (eor_rise && en_abn_ff && lost_ff && I_CTL.read_ctl) begin
						dly_ff <= tci_pkg::TCI_DLY_RUN;
					end
				end
				tci_pkg::TCI_DLY_RUN: begin
					if (fn_wr) begin
						dly_ff <= tci_pkg::TCI_DLY_IDLE;
					end else if (dly_done) begin
						dly_ff <= tci_pkg::TCI_DLY_FIRE;
					end
				end
				tci_pkg::TCI_DLY_FIRE: dly_ff <= tci_pkg::TCI_DLY_IDLE;
				default: dly_ff <= tci_pkg::TCI_DLY_IDLE;
			endcase
		end
	end

	// Interrupt flag; set sources win over clear
	logic set_rdy, set_eop, set_abn_now, set_abn_drop;
	assign set_rdy      = en_ready_ff && hdl_s.ready && !hdl_s.busy;
	assign set_eop      = en_eop_ff && eor_rise && idle_seen_ff;
	assign set_abn_now  = en_abn_ff && eor_rise && abn_cond
		&& !(lost_ff && I_CTL.read_ctl);
	// Ready lost mid-operation is improper
	assign set_abn_drop = en_abn_ff && ready_d_ff && !hdl_s.ready
		&& (I_CTL.read_ctl || I_CTL.write_ctl || I_CTL.write_motion);
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			int_ff     <= 1'b0;
			abn_hit_ff <= 1'b0;
		end else if (I_CE) begin
			if (set_rdy || set_eop || set_abn_now || set_abn_drop
				|| dly_ff == tci_pkg::TCI_DLY_FIRE) begin
				int_ff <= 1'b1;
				abn_hit_ff <= abn_hit_ff || set_abn_now || set_abn_drop
					|| (dly_ff == tci_pkg::TCI_DLY_FIRE);
			end else if ((fn_wr && fn[`TCI_FN_IRQ_SEL])
				|| !(en_ready_ff || en_eop_ff || en_abn_ff)) begin
				int_ff     <= 1'b0;
				abn_hit_ff <= 1'b0;
			end
		end
	end
	assign O_INTERRUPT = int_ff;
	assign O_INT_LAMP  = int_ff;

	// Lost data: write gap timer and read overrun
	logic gap_done;
	tci_timer #(.W(12)) u_gap (
		.i_clk   (I_REF_CLK),
		.i_rst   (I_RST),
		.i_ce    (I_CE),
		.i_clr   (chan_data_s),
		.i_run   (I_CTL.write_ctl),
		.i_limit (12'(`TCI_LOST_CYC - 1)),
		.o_done  (gap_done)
	);
	assign lost_wr = gap_done;
	assign lost_rd = I_CTL.read_ctl && spr_rise && hold_full_ff;
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			lost_ff <= 1'b0;
		end else if (I_CE) begin
			if (lost_wr || lost_rd) begin
				lost_ff <= 1'b1;
			end else if (fn_wr || connect_new) begin
				lost_ff <= 1'b0;
			end
		end
	end

	// Holding register released when host drops data
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			hold_full_ff <= 1'b0;
			hold_ff      <= 32'h0000_0000;
		end else if (I_CE) begin
			if (spr_rise && I_CTL.read_ctl && !hold_full_ff) begin
				hold_full_ff <= 1'b1;
				hold_ff      <= {26'h0, hdl_s[5:0]};
			end else if (hold_full_ff && !chan_data_s && busy_d_ff) begin
				hold_full_ff <= 1'b0;
			end
		end
	end

	// Record disconnect to channel, ends after check character
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			eor_disc_ff <= 1'b0;
		end else if (I_CE) begin
			if (lost_ff && I_CTL.read_ctl) begin
				eor_disc_ff <= 1'b1;
			end else if (chk_s || fn_wr) begin
				eor_disc_ff <= 1'b0;
			end
		end
	end
	assign O_EOR_TO_CHAN = eor_disc_ff;

	// Unloaded handlers stay blocked until software marks reload
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			unload_ff <= 8'h00;
		end else if (I_CE && fn_wr) begin
			if (fn[`TCI_FN_REW_UNLOAD] && !unload_ff[hsel]) begin
				unload_ff[hsel] <= 1'b1;
			end else if (fn[`TCI_FN_CLR_UNLOAD]) begin
				unload_ff[hsel] <= 1'b0;
			end
		end
	end
	assign unusable  = unload_ff[hsel];
	assign motion_ok = ctrl_ff[0] && !unusable && !(int_ff && abn_hit_ff);

	// Motion directives out to the handler
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			rew_unl_ff <= 1'b0;
			read_ff    <= 1'b0;
			write_ff   <= 1'b0;
		end else if (I_CE) begin
			rew_unl_ff <= fn_wr && fn[`TCI_FN_REW_UNLOAD] && motion_ok;
			if (fn_wr) begin
				read_ff  <= fn[`TCI_FN_READ] && motion_ok && !lost_ff;
				write_ff <= fn[`TCI_FN_WRITE] && motion_ok && !lost_ff;
			end else if (hdl_s.end_of_record) begin
				read_ff  <= 1'b0;
				write_ff <= 1'b0;
			end
		end
	end
	assign O_REWIND_UNLOAD = rew_unl_ff;
	assign O_READ_START    = read_ff;
	assign O_WRITE_SELECT  = write_ff;

	// Status lines, gated by connect
	always_comb begin
		status_raw[0]  = hdl_s.ready;
		status_raw[1]  = hdl_s.ready && (hdl_s.busy || I_CTL.write_ctl
			|| I_CTL.read_ctl || I_CTL.write_motion
			|| (chan_busy_s && lost_ff && chan_int_s));
		status_raw[2]  = hdl_s.write_en;
		status_raw[3]  = hdl_s.file_mark;
		status_raw[4]  = hdl_s.load_point;
		status_raw[5]  = hdl_s.end_of_tape;
		// Neither density line means 200, shown as both bits
		status_raw[6]  = hdl_s.dens_556 || !(hdl_s.dens_556 || hdl_s.dens_800);
		status_raw[7]  = hdl_s.dens_800 || !(hdl_s.dens_556 || hdl_s.dens_800);
		status_raw[8]  = lost_ff;
		status_raw[9]  = idle_seen_ff && hdl_s.end_of_record;
		status_raw[10] = I_CTL.vpar_err || I_CTL.lpar_err;
	end
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_STATUS <= 11'h000;
		end else if (I_CE) begin
			O_STATUS <= ctrl_ff[0] ? status_raw : 11'h000;
		end
	end

	// Write data shadow register
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			wdata_ff <= 32'h0000_0000;
		end else if (I_CE && wr_acc && I_PADDR == `TCI_OFF_WDATA) begin
			wdata_ff <= I_PWDATA;
		end
	end

	// Read mux, registered at setup so data is ready in access
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			rdata_ff <= 32'h0000_0000;
		end else if (I_CE && I_PSEL && !I_PENABLE && !I_PWRITE) begin
			case (I_PADDR)
				`TCI_OFF_CTRL:   rdata_ff <= {28'h0, ctrl_ff};
				`TCI_OFF_FUNC:   rdata_ff <= {28'h0, en_abn_ff, en_eop_ff,
					en_ready_ff, 1'b0};
				`TCI_OFF_STATUS: rdata_ff <= {21'h0, O_STATUS};
				`TCI_OFF_EVENT:  rdata_ff <= {24'h0, unusable, eor_disc_ff,
					hold_full_ff, abn_hit_ff, lost_ff, idle_seen_ff, int_ff, 1'b0};
				`TCI_OFF_RDATA:  rdata_ff <= hold_ff;
				`TCI_OFF_WDATA:  rdata_ff <= wdata_ff;
				default:         rdata_ff <= 32'h0000_0000;
			endcase
		end
	end
	assign O_PRDATA = rdata_ff;
endmodule

// file: tb/tci_top_chk.sv
`include "tci_params.svh"
module tci_chk (
	// Clock and reset
	input wire logic              I_REF_CLK,
	input wire logic              I_RST,
	// APB side
	input wire logic              I_PSEL,
	input wire logic              I_PENABLE,
	input wire logic              I_PWRITE,
	input wire logic [11:0]       I_PADDR,
	input wire logic [31:0]       I_PWDATA,
	input wire logic              O_PREADY,
	// Channel and handler side
	input wire logic              O_INTERRUPT,
	input wire logic              O_INT_LAMP,
	input wire logic              O_EOR_TO_CHAN,
	input wire logic [10:0]       O_STATUS,
	input wire logic              O_REWIND_UNLOAD,
	input wire tci_pkg::tci_ctl_t I_CTL
);
	default clocking @(posedge I_REF_CLK);
	endclocking
	default disable iff (I_RST);
	logic acc;
	logic fn_wr;
	logic rew_wr;
	logic conn_ff;
	// Completed APB writes, decoded from the bus itself
	assign acc    = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
	assign fn_wr  = acc & (I_PADDR == `TCI_OFF_FUNC);
	assign rew_wr = fn_wr & I_PWDATA[`TCI_FN_REW_UNLOAD];
	// Connect mirror; status lines must stay dark without it
	always_ff @(posedge I_REF_CLK or posedge I_RST) begin
		if (I_RST) begin
			conn_ff <= 1'h0;
		end else if (acc && I_PADDR == `TCI_OFF_CTRL) begin
			conn_ff <= I_PWDATA[`TCI_CTRL_CONNECT];
		end
	end
	AST_INT_LAMP: assert property (O_INT_LAMP == O_INTERRUPT)
		else $error("lamp differs from interrupt line");
	AST_INT_HOLD: assert property ($fell(O_INTERRUPT) |-> $past(fn_wr) || $past(fn_wr, 2))
		else $error("interrupt dropped without a function write");
	AST_RST_CLR: assert property ($fell(I_RST) |-> !O_INTERRUPT && O_STATUS == 11'h000)
		else $error("state not cleared by reset");
	AST_STATUS_OFF: assert property (!conn_ff && !$past(conn_ff) |-> O_STATUS == 11'h000)
		else $error("status active while disconnected");
	AST_BIT1_READY: assert property (O_STATUS[1] |-> O_STATUS[0])
		else $error("status bit 1 without ready");
	AST_DENSITY: assert property (conn_ff && $past(conn_ff, 3) |-> O_STATUS[7:6] != 2'h0)
		else $error("density code empty while connected");
	AST_REW_SRC: assert property (O_REWIND_UNLOAD |-> $past(rew_wr) || $past(rew_wr, 2))
		else $error("rewind unload without directive");
	AST_REW_PULSE: assert property (O_REWIND_UNLOAD |=> !O_REWIND_UNLOAD)
		else $error("rewind unload longer than one cycle");
	AST_EOR_READ: assert property ($rose(O_EOR_TO_CHAN) |-> I_CTL.read_ctl || $past(I_CTL.read_ctl))
		else $error("record disconnect outside read control");
	// Main scenarios reached
	cover property ($rose(O_INTERRUPT));
	cover property (O_REWIND_UNLOAD);
	cover property ($rose(O_STATUS[8]));
endmodule
bind tci_top tci_chk u_chk (
	.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
	.I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
	.O_INTERRUPT(O_INTERRUPT), .O_INT_LAMP(O_INT_LAMP), .O_EOR_TO_CHAN(O_EOR_TO_CHAN),
	.O_STATUS(O_STATUS), .O_REWIND_UNLOAD(O_REWIND_UNLOAD), .I_CTL(I_CTL)
);

// file: tb/tci_chan_model.sv
module tci_chan_model (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Bench requests
	input  wire logic       i_busy_req,
	input  wire logic       i_data_req,
	input  wire logic [7:0] i_ack_dly,
	input  wire logic       i_irq,
	// Channel lines
	output logic            o_busy,
	output logic            o_data,
	output logic            o_int
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_ff;
	// Busy and seen interrupt change only after an edge
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_busy <= 1'h0;
			o_int  <= 1'h0;
		end else begin
			o_busy <= i_busy_req;
			o_int  <= i_irq;
		end
	end
	// Host drops data once it has taken the word; a long delay models a slow host
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst || !i_data_req) begin
			cnt_ff <= 8'h00;
			o_data <= 1'h0;
		end else begin
			cnt_ff <= (cnt_ff == 8'hFF) ? cnt_ff : cnt_ff + 8'h01;
			o_data <= (cnt_ff < i_ack_dly);
		end
	end
endmodule

// file: tb/tci_top_test.sv
`include "tci_params.svh"
module tci_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic              ref_clk = 1'h0;
	logic              rst = 1'h1;
	logic              psel = 1'h0;
	logic              penable = 1'h0;
	logic              pwrite = 1'h0;
	logic [11:0]       paddr = 12'h000;
	logic [31:0]       pwdata = 32'h0;
	logic              busy_req = 1'h0;
	logic              data_req = 1'h0;
	logic [7:0]        ack_dly = 8'hFF;
	logic              sprocket = 1'h0;
	logic              chk_char = 1'h0;
	tci_pkg::tci_hdl_t hdl = '0;
	tci_pkg::tci_ctl_t ctl = '0;
	logic [31:0]       prdata;
	logic [31:0]       rd;
	logic [10:0]       status;
	logic              pready, pslverr, slv, chan_busy, chan_data, chan_int;
	logic              irq, lamp, eor_chan, rew, rd_start, wr_sel;
	int                errors = 0;
	int                comparisons = 0;
	int                rew_cnt = 0;
	logic [14:0]       vec [6] = '{15'h4000, 15'h6000, 15'h4120, 15'h4094, 15'h1E8A, 15'h5208};
	always #5 ref_clk = ~ref_clk;
	tci_top uut (
		.I_REF_CLK(ref_clk), .I_RST(rst), .I_CE(1'h1), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_CHAN_BUSY(chan_busy),
		.I_CHAN_DATA(chan_data), .I_CHAN_INT(chan_int), .O_INTERRUPT(irq), .O_INT_LAMP(lamp),
		.O_EOR_TO_CHAN(eor_chan), .O_STATUS(status), .I_HDL(hdl), .I_READ_SPROCKET(sprocket),
		.I_CHECK_CHAR(chk_char), .O_REWIND_UNLOAD(rew), .O_READ_START(rd_start),
		.O_WRITE_SELECT(wr_sel), .I_CTL(ctl)
	);
	tci_chan_model u_chan (
		.i_clk(ref_clk), .i_rst(rst), .i_busy_req(busy_req), .i_data_req(data_req),
		.i_ack_dly(ack_dly), .i_irq(irq), .o_busy(chan_busy), .o_data(chan_data),
		.o_int(chan_int)
	);
	// Count rewind-unload pulses seen at the handler
	always @(posedge ref_clk) if (rew === 1'h1) rew_cnt++;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		@(posedge ref_clk);
		while (pready !== 1'h1) @(posedge ref_clk);
		rd = prdata;
		slv = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic wait_irq(input logic exp, input int lim);
		for (int n = 0; n < lim && irq !== exp; n++) @(posedge ref_clk);
		check(irq, exp);
	endtask
	// Status expected from handler and controller levels, no lost data or idle seen
	function automatic logic [10:0] exp_st(input tci_pkg::tci_hdl_t h, input tci_pkg::tci_ctl_t c);
		logic [10:0] s;
		s = {c.vpar_err | c.lpar_err, 2'h0, h.dens_800 | ~h.dens_556,
			h.dens_556 | ~h.dens_800, h.end_of_tape, h.load_point, h.file_mark, h.write_en,
			h.ready & (h.busy | c.write_ctl | c.read_ctl | c.write_motion), h.ready};
		return s;
	endfunction
	task automatic end_of_test;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#300000;
		errors++;
		end_of_test();
	end
	initial begin
		cyc(6);
		rst <= 1'h0;
		cyc(3);
		apb(1'h0, `TCI_OFF_FUNC, 32'h0);
		check(rd, 32'h0);
		apb(1'h0, `TCI_OFF_STATUS, 32'h0);
		check(rd, 32'h0);
		apb(1'h0, 12'h0F0, 32'h0);
		check(slv, 1'h1);
		// Status lines follow handler and controller levels
		apb(1'h1, `TCI_OFF_CTRL, 32'h1);
		for (int i = 0; i < 6; i++) begin
			hdl <= vec[i][14:6];
			ctl <= vec[i][5:0];
			cyc(6);
			check(status, exp_st(hdl, ctl));
			apb(1'h0, `TCI_OFF_STATUS, 32'h0);
			check(rd, {21'h0, exp_st(hdl, ctl)});
		end
		// Interrupt on ready, held until a new select code
		ctl <= '0;
		hdl <= 9'h100;
		apb(1'h1, `TCI_OFF_FUNC, 32'h3);
		wait_irq(1'h1, 10);
		check(lamp, 1'h1);
		apb(1'h0, `TCI_OFF_FUNC, 32'h0);
		check(rd, 32'h2);
		cyc(50);
		check(irq, 1'h1);
		apb(1'h1, `TCI_OFF_FUNC, 32'h1);
		wait_irq(1'h0, 10);
		// End of operation needs idle seen on the channel
		hdl <= 9'h180;
		apb(1'h1, `TCI_OFF_FUNC, 32'h5);
		busy_req <= 1'h1;
		cyc(5);
		busy_req <= 1'h0;
		cyc(6);
		apb(1'h0, `TCI_OFF_EVENT, 32'h0);
		check(rd[2], 1'h1);
		check(irq, 1'h0);
		hdl.end_of_record <= 1'h1;
		wait_irq(1'h1, 10);
		check(status[9], 1'h1);
		hdl <= 9'h110;
		apb(1'h1, `TCI_OFF_FUNC, 32'h9);
		wait_irq(1'h0, 10);
		// Load point counts only at end of record
		cyc(6);
		check(irq, 1'h0);
		hdl.end_of_record <= 1'h1;
		wait_irq(1'h1, 10);
		hdl <= 9'h100;
		apb(1'h1, `TCI_OFF_FUNC, 32'h9);
		wait_irq(1'h0, 10);
		ctl.write_motion <= 1'h1;
		hdl.ready <= 1'h0;
		wait_irq(1'h1, 10);
		ctl <= '0;
		hdl <= 9'h100;
		apb(1'h1, `TCI_OFF_FUNC, 32'h9);
		// Write lost data at the two-frame boundary
		ctl.write_ctl <= 1'h1;
		cyc(`TCI_LOST_CYC - 100);
		check(status[8], 1'h0);
		cyc(200);
		check(status[8], 1'h1);
		// Abnormal interrupt is taken at end of record
		hdl.end_of_record <= 1'h1;
		wait_irq(1'h1, 10);
		ctl <= '0;
		hdl <= 9'h100;
		apb(1'h1, `TCI_OFF_FUNC, 32'h20);
		cyc(6);
		check(rd_start, 1'h0);
		check(status[8], 1'h0);
		ctl.write_ctl <= 1'h1;
		cyc(`TCI_LOST_CYC + 100);
		ctl <= '0;
		apb(1'h1, `TCI_OFF_CTRL, 32'h0);
		apb(1'h1, `TCI_OFF_CTRL, 32'h1);
		cyc(6);
		check(status[8], 1'h0);
		// Read lost data with a slow host, delayed interrupt
		apb(1'h1, `TCI_OFF_FUNC, 32'h9);
		ctl.read_ctl <= 1'h1;
		data_req <= 1'h1;
		repeat (2) begin
			sprocket <= 1'h1;
			cyc(4);
			sprocket <= 1'h0;
			cyc(20);
		end
		check(status[8], 1'h1);
		check(eor_chan, 1'h1);
		hdl.end_of_record <= 1'h1;
		cyc(`TCI_ABN_DLY_CYC - 50);
		check(irq, 1'h0);
		wait_irq(1'h1, 100);
		ctl <= '0;
		data_req <= 1'h0;
		hdl <= 9'h180;
		// Check character ends the record disconnect
		chk_char <= 1'h1;
		cyc(5);
		check(eor_chan, 1'h0);
		chk_char <= 1'h0;
		apb(1'h1, `TCI_OFF_FUNC, 32'h1);
		apb(1'h1, `TCI_OFF_FUNC, 32'h60);
		cyc(2);
		check(rd_start, 1'h1);
		check(wr_sel, 1'h1);
		// Rewind unload makes the handler unusable until reload
		apb(1'h1, `TCI_OFF_FUNC, 32'h10);
		cyc(3);
		check(rew_cnt, 1);
		apb(1'h0, `TCI_OFF_EVENT, 32'h0);
		check(rd[7], 1'h1);
		apb(1'h1, `TCI_OFF_FUNC, 32'h10);
		cyc(3);
		check(rew_cnt, 1);
		apb(1'h1, `TCI_OFF_CTRL, 32'h3);
		apb(1'h0, `TCI_OFF_EVENT, 32'h0);
		check(rd[7], 1'h0);
		// Reload mark frees the first handler again
		apb(1'h1, `TCI_OFF_CTRL, 32'h1);
		apb(1'h1, `TCI_OFF_FUNC, 32'h80);
		apb(1'h0, `TCI_OFF_EVENT, 32'h0);
		check(rd[7], 1'h0);
		// Master clear in mid-run
		hdl <= 9'h100;
		apb(1'h1, `TCI_OFF_FUNC, 32'h3);
		wait_irq(1'h1, 10);
		rst <= 1'h1;
		cyc(2);
		rst <= 1'h0;
		cyc(1);
		check(irq, 1'h0);
		apb(1'h0, `TCI_OFF_FUNC, 32'h0);
		check(rd, 32'h0);
		end_of_test();
	end
endmodule
